// [swcfg_cfg.svh]
`ifndef SWCFG_CFG_SVH
`define SWCFG_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// command codes
`define SWCFG_CMD_FREQ      8'h33
`define SWCFG_CMD_POWER     8'h34
`define SWCFG_CMD_PHASE     8'h37

////////////////////////////////////////////////////////////////////////////////
// linear-11 field positions
`define SWCFG_EXP_MSB       15
`define SWCFG_EXP_LSB       11
`define SWCFG_MAN_MSB       10
`define SWCFG_MAN_SIGN      10

////////////////////////////////////////////////////////////////////////////////
// frequency plan, frequencies in khz, divisor limits unitless
`define SWCFG_REF_KHZ       48'd30000
`define SWCFG_F_MIN_KHZ     48'd200
`define SWCFG_F_MAX_KHZ     48'd1000
`define SWCFG_DIV_MIN       8'd30
`define SWCFG_DIV_MAX       8'd150

////////////////////////////////////////////////////////////////////////////////
// field positions and reset values
`define SWCFG_DEM_BIT       0
`define SWCFG_POS_MSB       3
`define SWCFG_POS_WRAP      5'd16
`define SWCFG_STEP_TENTHS   12'd225
`define SWCFG_FREQ_RST      16'h0000
`define SWCFG_DIV_RST       8'd60
`define SWCFG_POWER_RST     8'h00
`define SWCFG_PHASE_RST     16'h0000

`endif

// [swcfg_pkg.sv]
package swcfg_pkg;

  typedef enum logic {
    ST_IDLE,
    ST_SEARCH
  } swcfg_state_t;

  typedef logic [15:0] swcfg_word_t;

endpackage

// [swcfg_top.sv]
`timescale 1ns/1ns
`include "swcfg_cfg.svh"
module swcfg_top import swcfg_pkg::*; (
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        CMD_WR_I,
  input  wire logic        CMD_RD_I,
  input  wire logic [7:0]  CMD_CODE_I,
  input  wire logic [15:0] CMD_DATA_I,
  input  wire logic [15:0] STRAP_FREQ_I,
  input  wire logic [6:0]  BUS_ADDR_I,
  input  wire logic        SHARE_GROUP_I,
  input  wire logic [3:0]  SHARE_POS_I,
  output logic      [15:0] RD_DATA_O,
  output logic             RD_VALID_O,
  output logic             ACK_O,
  output logic             REJECT_O,
  output logic             BUSY_O,
  output logic      [7:0]  FREQ_DIVISOR_O,
  output logic             DIODE_EMULATION_O,
  output logic      [4:0]  PHASE_POS_O,
  output logic      [11:0] PHASE_DELAY_O
);

  //////////////////////////////////////////////////////////////////////////////
  // compares y * 2^n * a against b exactly; returns {greater, equal}
  function automatic logic [1:0] lin_cmp(input swcfg_word_t v,
                                         input logic [47:0] a,
                                         input logic [47:0] b);
    logic signed [5:0] e;
    logic        [5:0] sh;
    logic        [47:0] y;
    logic        [47:0] l;
    logic        [47:0] r;
    e  = {v[`SWCFG_EXP_MSB], v[`SWCFG_EXP_MSB:`SWCFG_EXP_LSB]};
    sh = e[5] ? 6'(-e) : 6'(e);
    y  = {37'h0, v[`SWCFG_MAN_MSB:0]};
    l  = y * a;
    r  = b;
    if (e[5]) begin
      r = b << sh;
    end else begin
      l = l << sh;
    end
    return {l > r, l == r};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic         loaded;
  swcfg_word_t  freq_set;
  logic [7:0]   power_set;
  swcfg_word_t  phase_set;
  logic         host_phase;
  swcfg_state_t state;
  logic [7:0]   div_n;
  logic         busy;

  //////////////////////////////////////////////////////////////////////////////
  // command decode
  wire          is_freq   = CMD_CODE_I == `SWCFG_CMD_FREQ;
  wire          is_power  = CMD_CODE_I == `SWCFG_CMD_POWER;
  wire          is_phase  = CMD_CODE_I == `SWCFG_CMD_PHASE;
  wire          known     = is_freq | is_power | is_phase;
  wire          wr_freq   = loaded & CMD_WR_I & is_freq;
  wire          wr_power  = loaded & CMD_WR_I & is_power;
  wire          wr_phase  = loaded & CMD_WR_I & is_phase;
  wire          rd_ok     = loaded & CMD_RD_I & known;
  wire          bad_code  = loaded & (CMD_RD_I | CMD_WR_I) & ~known;

  // first cycle after reset takes the strap, later ones the host
  wire          load_freq = ~loaded | wr_freq;
  wire swcfg_word_t load_val = loaded ? CMD_DATA_I : STRAP_FREQ_I;
  wire [1:0]    cmp_lo    = lin_cmp(load_val, 48'd1, `SWCFG_F_MIN_KHZ);
  wire [1:0]    cmp_hi    = lin_cmp(load_val, 48'd1, `SWCFG_F_MAX_KHZ);
  wire          load_ok   = ~load_val[`SWCFG_MAN_SIGN] & (|cmp_lo) & ~cmp_hi[1];
  wire          freq_bad  = wr_freq & ~load_ok;
  wire          start     = load_freq & load_ok;

  //////////////////////////////////////////////////////////////////////////////
  // divisor search: n is nearest once f*2n(n+1) >= ref*(2n+1)
  wire [47:0]   n_w       = {40'h0, div_n};
  wire [47:0]   mul_a     = 48'd2 * n_w * (n_w + 48'd1);
  wire [47:0]   mul_b     = `SWCFG_REF_KHZ * (48'd2 * n_w + 48'd1);
  wire [1:0]    cmp_mid   = lin_cmp(freq_set, mul_a, mul_b);
  wire          hit       = (|cmp_mid) | (div_n == `SWCFG_DIV_MAX);

  //////////////////////////////////////////////////////////////////////////////
  // phase position
  wire          auto_grp  = SHARE_GROUP_I & ~host_phase;
  wire [3:0]    pos_src   = auto_grp ? SHARE_POS_I : phase_set[`SWCFG_POS_MSB:0];
  wire [4:0]    pos_eff   = (pos_src == 4'h0) ? `SWCFG_POS_WRAP : {1'b0, pos_src};
  wire [11:0]   delay_eff = 12'({7'h0, pos_eff} * `SWCFG_STEP_TENTHS);

  wire [15:0]   rd_mux    = is_freq  ? freq_set :
                            is_power ? {8'h0, power_set} : phase_set;

  //////////////////////////////////////////////////////////////////////////////
  // stored commands
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      loaded <= 1'b0;
      freq_set <= `SWCFG_FREQ_RST;
    end else begin
      loaded <= 1'b1;
      // outputs are assumed off while this is written; no interlock here
      if (start) begin
        freq_set <= load_val;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      power_set <= `SWCFG_POWER_RST;
    end else if (wr_power) begin
      power_set <= {7'h0, CMD_DATA_I[`SWCFG_DEM_BIT]};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      phase_set <= `SWCFG_PHASE_RST;
      host_phase <= 1'b0;
    end else if (~loaded) begin
      phase_set <= {12'h0, BUS_ADDR_I[`SWCFG_POS_MSB:0]};
    end else if (wr_phase) begin
      phase_set <= {12'h0, CMD_DATA_I[`SWCFG_POS_MSB:0]};
      host_phase <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // search machine
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state <= ST_IDLE;
      div_n <= `SWCFG_DIV_MIN;
      FREQ_DIVISOR_O <= `SWCFG_DIV_RST;
      busy <= 1'b0;
    end else if (start) begin
      state <= ST_SEARCH;
      div_n <= `SWCFG_DIV_MIN;
      busy <= 1'b1;
    end else begin
      unique case (state)
        ST_IDLE: begin
          busy <= 1'b0;
        end
        ST_SEARCH: begin
          if (hit) begin
            FREQ_DIVISOR_O <= div_n;
            state <= ST_IDLE;
            busy <= 1'b0;
          end else begin
            div_n <= div_n + 8'd1;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // answers and derived outputs
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      RD_DATA_O <= 16'h0000;
      RD_VALID_O <= 1'b0;
      ACK_O <= 1'b0;
      REJECT_O <= 1'b0;
      PHASE_POS_O <= `SWCFG_POS_WRAP;
      PHASE_DELAY_O <= 12'h000;
    end else begin
      RD_DATA_O <= rd_ok ? rd_mux : 16'h0000;
      RD_VALID_O <= rd_ok;
      ACK_O <= loaded & CMD_WR_I & known & ~freq_bad;
      REJECT_O <= bad_code | freq_bad;
      PHASE_POS_O <= pos_eff;
      PHASE_DELAY_O <= delay_eff;
    end
  end

  assign BUSY_O = busy;
  assign DIODE_EMULATION_O = power_set[`SWCFG_DEM_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // checks
  localparam int SEARCH_MAX = 122;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);

  property p_reject_range;
    wr_freq && !load_ok |=> REJECT_O && !ACK_O && $stable(freq_set);
  endproperty
  a_reject_range: assert property (p_reject_range) else $error("bad frequency not refused");

  property p_keep_old;
    wr_freq && !load_ok && !busy |=> !busy && $stable(FREQ_DIVISOR_O) && $stable(freq_set);
  endproperty
  a_keep_old: assert property (p_keep_old) else $error("refused write moved divisor");

  property p_accept_store;
    wr_freq && load_ok |=> ACK_O && freq_set == $past(CMD_DATA_I) && busy;
  endproperty
  a_accept_store: assert property (p_accept_store) else $error("good frequency not stored");

  property p_div_range;
    FREQ_DIVISOR_O >= `SWCFG_DIV_MIN && FREQ_DIVISOR_O <= `SWCFG_DIV_MAX;
  endproperty
  a_div_range: assert property (p_div_range) else $error("divisor out of range");

  property p_search_ends;
    start |=> ##[0:SEARCH_MAX] (!busy || start);
  endproperty
  a_search_ends: assert property (p_search_ends) else $error("divisor search hung");

  property p_search_pick;
    state == ST_SEARCH && (|cmp_mid) && !start |=> FREQ_DIVISOR_O == $past(div_n) && !busy;
  endproperty
  a_search_pick: assert property (p_search_pick) else $error("nearest divisor not taken");

  property p_strap_load;
    $rose(loaded) |-> freq_set == $past(STRAP_FREQ_I) || !$past(load_ok);
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap frequency not loaded");

  property p_power_bits;
    power_set[7:1] == 7'h0 && DIODE_EMULATION_O == power_set[0];
  endproperty
  a_power_bits: assert property (p_power_bits) else $error("efficiency upper bits set");

  property p_power_write;
    wr_power |=> DIODE_EMULATION_O == $past(CMD_DATA_I[0]);
  endproperty
  a_power_write: assert property (p_power_write) else $error("diode emulation not updated");

  property p_power_reset;
    $rose(loaded) |-> power_set == `SWCFG_POWER_RST && !DIODE_EMULATION_O;
  endproperty
  a_power_reset: assert property (p_power_reset) else $error("efficiency mode not cleared");

  property p_addr_init;
    $rose(loaded) |-> phase_set == {12'h0, $past(BUS_ADDR_I[3:0])};
  endproperty
  a_addr_init: assert property (p_addr_init) else $error("interleave not from address");

  property p_wrap16;
    pos_src == 4'h0 |=> PHASE_POS_O == 5'd16 && PHASE_DELAY_O == 12'd3600;
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("zero position not sixteen");

  property p_auto_group;
    SHARE_GROUP_I && !host_phase && SHARE_POS_I != 4'h0 |=> PHASE_POS_O == {1'b0, $past(SHARE_POS_I)};
  endproperty
  a_auto_group: assert property (p_auto_group) else $error("group phase not automatic");

  property p_readback;
    rd_ok && is_phase |=> RD_VALID_O && RD_DATA_O == $past(phase_set);
  endproperty
  a_readback: assert property (p_readback) else $error("interleave readback wrong");

  c_freq_ok:   cover property (wr_freq && load_ok ##1 busy ##[1:SEARCH_MAX] !busy);
  c_freq_bad:  cover property (wr_freq && !load_ok ##1 REJECT_O);
  c_dem_on:    cover property (wr_power && CMD_DATA_I[0] ##1 DIODE_EMULATION_O);
  c_phase_wr:  cover property (wr_phase ##1 host_phase);

endmodule

// [swcfg_host.sv]
`timescale 1ns/1ns
module swcfg_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic        reject_i,
  input  wire logic        rd_valid_i,
  input  wire logic [15:0] rd_data_i,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [7:0]  code_o,
  output logic      [15:0] data_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    code_o = 8'h00;
    data_o = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // frequency writes are only issued while the output is held off
  // a sync-driven system sets the nearest frequency to the sync clock
  task automatic xfer(input logic is_wr, input logic [7:0] code, input logic [15:0] data,
                      output logic [1:0] resp, output logic [15:0] rdata);
    @(posedge clk_i);
    wr_o <= is_wr;
    rd_o <= ~is_wr;
    code_o <= code;
    data_o <= data;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    // released lines stop showing the last word
    code_o <= ~code;
    data_o <= ~data;
    #1;
    resp = {reject_i, ack_i | rd_valid_i};
    rdata = rd_data_i;
  endtask
endmodule

// [swcfg_top_tb.sv]
`timescale 1ns/1ns
module swcfg_top_tb;
  logic        CLK_I = 1'b0;
  logic        RESET_I = 1'b1;
  logic        CMD_WR_I;
  logic        CMD_RD_I;
  logic [7:0]  CMD_CODE_I;
  logic [15:0] CMD_DATA_I;
  logic [15:0] STRAP_FREQ_I = 16'h0258;
  logic [6:0]  BUS_ADDR_I = 7'h25;
  logic        SHARE_GROUP_I = 1'b0;
  logic [3:0]  SHARE_POS_I = 4'h3;
  logic [15:0] RD_DATA_O;
  logic        RD_VALID_O;
  logic        ACK_O;
  logic        REJECT_O;
  logic        BUSY_O;
  logic [7:0]  FREQ_DIVISOR_O;
  logic        DIODE_EMULATION_O;
  logic [4:0]  PHASE_POS_O;
  logic [11:0] PHASE_DELAY_O;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc = 0;

  always #10 CLK_I = ~CLK_I;

  swcfg_top dut (.CLK_I(CLK_I), .RESET_I(RESET_I), .CMD_WR_I(CMD_WR_I), .CMD_RD_I(CMD_RD_I),
    .CMD_CODE_I(CMD_CODE_I), .CMD_DATA_I(CMD_DATA_I), .STRAP_FREQ_I(STRAP_FREQ_I),
    .BUS_ADDR_I(BUS_ADDR_I), .SHARE_GROUP_I(SHARE_GROUP_I), .SHARE_POS_I(SHARE_POS_I),
    .RD_DATA_O(RD_DATA_O), .RD_VALID_O(RD_VALID_O), .ACK_O(ACK_O), .REJECT_O(REJECT_O),
    .BUSY_O(BUSY_O), .FREQ_DIVISOR_O(FREQ_DIVISOR_O), .DIODE_EMULATION_O(DIODE_EMULATION_O),
    .PHASE_POS_O(PHASE_POS_O), .PHASE_DELAY_O(PHASE_DELAY_O));

  swcfg_host host (.clk_i(CLK_I), .ack_i(ACK_O), .reject_i(REJECT_O), .rd_valid_i(RD_VALID_O),
    .rd_data_i(RD_DATA_O), .wr_o(CMD_WR_I), .rd_o(CMD_RD_I), .code_o(CMD_CODE_I), .data_o(CMD_DATA_I));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // resp is {reject, ack or read valid}; read data is zero outside a read answer
  task automatic op(input logic w, input logic [7:0] c, input logic [15:0] d,
                    input logic [1:0] er, input logic [15:0] ed);
    logic [1:0]  r;
    logic [15:0] q;
    host.xfer(w, c, d, r, q);
    chk({14'h0000, r}, {14'h0000, er});
    chk(q, ed);
  endtask

  task automatic wait_idle;
    int i;
    i = 0;
    while (BUSY_O !== 1'b0 && i < 300) begin
      @(posedge CLK_I);
      i++;
    end
    @(posedge CLK_I);
    #1;
    chk({15'h0000, BUSY_O}, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    repeat (4) @(posedge CLK_I);
    #1;
    chk({8'h00, FREQ_DIVISOR_O}, 16'h003c);
    chk({15'h0000, DIODE_EMULATION_O}, 16'h0000);
    @(posedge CLK_I);
    RESET_I <= 1'b0;
    op(1'b0, 8'h33, 16'h0000, 2'b01, 16'h0258);
    wait_idle();
    chk({8'h00, FREQ_DIVISOR_O}, 16'h0032);
    op(1'b0, 8'h34, 16'h0000, 2'b01, 16'h0000);
    op(1'b0, 8'h37, 16'h0000, 2'b01, 16'h0005);
    chk({11'h000, PHASE_POS_O}, 16'h0005);
    chk({4'h0, PHASE_DELAY_O}, 16'h0465);
    @(posedge CLK_I);
    SHARE_GROUP_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    #1;
    chk({11'h000, PHASE_POS_O}, 16'h0003);
    op(1'b0, 8'h37, 16'h0000, 2'b01, 16'h0005);
    $display("test reset done");
  endtask

  task automatic t_freq;
    logic [15:0] w [4] = '{16'h03e8, 16'h00c8, 16'h014d, 16'h0977};
    logic [7:0]  n [4] = '{8'd30, 8'd150, 8'd90, 8'd40};
    logic [15:0] bad [3] = '{16'h03e9, 16'h00c7, 16'h07ff};
    for (int i = 0; i < 4; i++) begin
      op(1'b1, 8'h33, w[i], 2'b01, 16'h0000);
      chk({15'h0000, BUSY_O}, 16'h0001);
      wait_idle();
      chk({8'h00, FREQ_DIVISOR_O}, {8'h00, n[i]});
      op(1'b0, 8'h33, 16'h0000, 2'b01, w[i]);
    end
    for (int i = 0; i < 3; i++) begin
      op(1'b1, 8'h33, bad[i], 2'b10, 16'h0000);
      repeat (3) @(posedge CLK_I);
      #1;
      chk({8'h00, FREQ_DIVISOR_O}, 16'h0028);
      op(1'b0, 8'h33, 16'h0000, 2'b01, 16'h0977);
    end
    op(1'b1, 8'h35, 16'h0001, 2'b10, 16'h0000);
    op(1'b0, 8'h35, 16'h0000, 2'b10, 16'h0000);
    $display("test freq done");
  endtask

  task automatic t_power;
    op(1'b1, 8'h34, 16'h00ff, 2'b01, 16'h0000);
    chk({15'h0000, DIODE_EMULATION_O}, 16'h0001);
    op(1'b0, 8'h34, 16'h0000, 2'b01, 16'h0001);
    op(1'b1, 8'h34, 16'h00fe, 2'b01, 16'h0000);
    chk({15'h0000, DIODE_EMULATION_O}, 16'h0000);
    $display("test power done");
  endtask

  task automatic t_phase;
    logic [15:0] w [2] = '{16'h0000, 16'hfff1};
    logic [15:0] p [2] = '{16'h0010, 16'h0001};
    logic [15:0] d [2] = '{16'h0e10, 16'h00e1};
    for (int i = 0; i < 2; i++) begin
      op(1'b1, 8'h37, w[i], 2'b01, 16'h0000);
      repeat (2) @(posedge CLK_I);
      #1;
      chk({11'h000, PHASE_POS_O}, p[i]);
      chk({4'h0, PHASE_DELAY_O}, d[i]);
      op(1'b0, 8'h37, 16'h0000, 2'b01, w[i] & 16'h000f);
    end
    $display("test phase done");
  endtask

  initial begin
    t_reset();
    t_freq();
    t_power();
    t_phase();
    end_of_test();
  end
endmodule
